// ==== bench/ecd_line_model.sv ====
// Serial line partner that plays the remote sender on the receive pin.
// Assumes start is a one-cycle mclk pulse from the bench.
`timescale 1ns/1ps

module ecd_line_model #(
   parameter int BIT_CLKS = 16
) (
   input  wire logic mclk,
   input  wire logic start,
   output logic      rx_pin
);
   int cnt_r = 0;   // Cycles left in the start bit

   // ===================================================
   // Start bit: line low for one bit time, else idle high
   always_ff @(posedge mclk) begin
      if (start) begin
         cnt_r <= BIT_CLKS;   // Falling edge opens a frame
      end else if (cnt_r != 0) begin
         cnt_r <= cnt_r - 1;
      end
   end

   // Pulled-up line, so idle reads high
   assign rx_pin = (cnt_r == 0);
endmodule

// ==== bench/economy_clock_divider_switchback_bench.sv ====
// Self-checking bench for the economy clock divider.
// Assumes the design package and a serial line partner model.
`timescale 1ns/1ps

`define CHK(nm, exp, got) begin \
   n_compared++; \
   if ((got) !== (exp)) begin \
      err_count++; \
      $display("unexpected %s exp %0h got %0h", nm, exp, got); \
   end \
end

module economy_clock_divider_switchback_bench import ecd_pkg::*;;
   // ===================================================
   // Stimulus and observed signals
   logic       mclk;
   logic       rstn       = 1'b0;
   ecd_wr_t    pmr_wr     = '0;
   ecd_wr_t    extended_interrupt_flag_register_wr    = '0;
   ecd_wr_t    amp_wr     = '0;
   logic       idle_req   = 1'b0;
   logic       pdown_req  = 1'b0;
   logic       wake       = 1'b0;
   logic       rst_cause  = 1'b0;
   logic       line_start = 1'b0;
   ecd_ser_t   ser        = '0;
   logic       rx_pin;
   logic       core_stb, periph_stb, xtal_amp_en, src_xtal;
   logic [7:0] pmr_rd, extended_interrupt_flag_register_rd, status_rd;
   int         err_count  = 0;
   int         n_compared = 0;

   // Short warm-up keeps the run brief
   ecd_clock_ctrl #(.WARMUP_CYCLES(8)) dut (
      .mclk        (mclk),
      .rstn        (rstn),
      .pmr_wr      (pmr_wr),
      .extended_interrupt_flag_register_wr     (extended_interrupt_flag_register_wr),
      .amp_off_wr  (amp_wr),
      .idle_req    (idle_req),
      .pdown_req   (pdown_req),
      .wake        (wake),
      .rst_cause   (rst_cause),
      .ser         (ser),
      .rx_pin      (rx_pin),
      .core_stb    (core_stb),
      .periph_stb  (periph_stb),
      .pmr_rd      (pmr_rd),
      .extended_interrupt_flag_register_rd     (extended_interrupt_flag_register_rd),
      .status_rd   (status_rd),
      .xtal_amp_en (xtal_amp_en),
      .src_xtal    (src_xtal)
   );

   ecd_line_model line (
      .mclk   (mclk),
      .start  (line_start),
      .rx_pin (rx_pin)
   );

   // 250 MHz clock
   initial begin
      mclk = 1'b0;
      forever #2 mclk = ~mclk;
   end

   // ===================================================
   // Shared helpers
   task automatic tick(input int n);
      repeat (n) @(negedge mclk);
   endtask

   // One-cycle write strobe: 0 divider, 1 source, 2 amplifier
   task automatic wr(input int sel, input logic [7:0] d);
      @(posedge mclk);
      case (sel)
         0: pmr_wr <= '{wr: 1'b1, data: d};
         1: extended_interrupt_flag_register_wr <= '{wr: 1'b1, data: d};
         default: amp_wr <= '{wr: 1'b1, data: d};
      endcase
      @(posedge mclk);
      pmr_wr.wr <= 1'b0;
      extended_interrupt_flag_register_wr.wr <= 1'b0;
      amp_wr.wr <= 1'b0;
   endtask

   // One-cycle event pulse selected by number
   task automatic pulse(input int sel);
      @(posedge mclk);
      case (sel)
         0: idle_req <= 1'b1;
         1: pdown_req <= 1'b1;
         2: wake <= 1'b1;
         3: rst_cause <= 1'b1;
         4: ser.tx_wr <= 1'b1;
         5: ser.int_ack <= 1'b1;
         default: line_start <= 1'b1;
      endcase
      @(posedge mclk);
      {idle_req, pdown_req, wake, rst_cause, line_start} <= '0;
      ser.tx_wr <= 1'b0;
      ser.int_ack <= 1'b0;
   endtask

   // Waits, bounded, for a machine strobe at a negedge
   task automatic stb_wait;
      int i;
      for (i = 0; i < 3000 && core_stb !== 1'b1; i++) @(negedge mclk);
   endtask

   // Cycles from the next strobe to the one after
   task automatic per(output int p);
      p = 0;
      @(negedge mclk);
      stb_wait();
      do begin
         @(negedge mclk);
         p++;
         `CHK("periph_stb", core_stb, periph_stb)
      end while (core_stb !== 1'b1 && p < 3000);
   endtask

   // Counts core and peripheral strobes over n cycles
   task automatic cnt(input int n, output int c, output int q);
      c = 0;
      q = 0;
      repeat (n) begin
         @(negedge mclk);
         c += (core_stb === 1'b1);
         q += (periph_stb === 1'b1);
      end
   endtask

   // ===================================================
   // Scenarios
   task automatic t_reset;
      int p;
      repeat (2) @(posedge mclk);
      rstn <= 1'b1;
      tick(1);
      `CHK("pmr_rd", 8'h40, pmr_rd)
      `CHK("extended_interrupt_flag_register_rd", 8'h0c, extended_interrupt_flag_register_rd)
      `CHK("status_rd", 8'h00, status_rd)
      per(p);
      `CHK("period", 4, p)
      tick(12);
      `CHK("status_rd", 8'h10, status_rd)
   endtask

   // Economy rates always entered from divide-by-4
   task automatic t_div;
      int p;
      wr(0, 8'h80);
      per(p);
      `CHK("period 64", 64, p)
      tick(1);
      `CHK("pmr_rd", 8'h80, pmr_rd)
      wr(0, 8'h00);
      per(p);
      `CHK("period rsvd", 64, p)
      wr(0, 8'h40);
      per(p);
      `CHK("period 4", 4, p)
      wr(0, 8'hc0);
      per(p);
      `CHK("period 1024", 1024, p)
      wr(0, 8'h40);
      tick(1);
      `CHK("pmr_rd pend", 8'hc0, pmr_rd)
      per(p);
      `CHK("period back", 4, p)
   endtask

   task automatic t_src;
      wr(1, 8'h00);
      tick(1);
      `CHK("select bit", 1'b0, extended_interrupt_flag_register_rd[3])
      stb_wait();
      `CHK("active old", 1'b1, extended_interrupt_flag_register_rd[2])
      tick(1);
      `CHK("extended_interrupt_flag_register_rd", 8'h00, extended_interrupt_flag_register_rd)
      `CHK("src_xtal", 1'b0, src_xtal)
      wr(2, 8'h01);
      tick(2);
      `CHK("amp_en", 1'b0, xtal_amp_en)
      `CHK("status_rd", 8'h00, status_rd)
      wr(1, 8'h08);
      tick(8);
      `CHK("extended_interrupt_flag_register_rd refused", 8'h00, extended_interrupt_flag_register_rd)
      // Amplifier back on before the crystal is chosen
      wr(2, 8'h00);
      tick(2);
      `CHK("amp_en", 1'b1, xtal_amp_en)
      tick(10);
      `CHK("status_rd", 8'h10, status_rd)
      wr(1, 8'h08);
      tick(8);
      `CHK("extended_interrupt_flag_register_rd", 8'h0c, extended_interrupt_flag_register_rd)
      `CHK("src_xtal", 1'b1, src_xtal)
   endtask

   // Transmit write, interrupt and start bit each switch back
   task automatic t_swb;
      int k;
      // Serial events run with the crystal as the source
      `CHK("src_xtal", 1'b1, src_xtal)
      @(posedge mclk);
      ser.rx_en <= 1'b1;
      for (k = 0; k < 3; k++) begin
         wr(0, 8'ha0);
         tick(8);
         `CHK("pmr_rd", 8'ha0, pmr_rd)
         pulse(4 + k);
         tick(8);
         `CHK("pmr_rd", 8'h60, pmr_rd)
      end
      @(posedge mclk);
      ser.busy <= 1'b1;
      wr(0, 8'ha0);
      tick(8);
      `CHK("pmr_rd busy", 8'h60, pmr_rd)
      @(posedge mclk);
      ser.busy <= 1'b0;
      wr(0, 8'h40);
      tick(8);
   endtask

   task automatic t_pwr;
      int c;
      int q;
      int p;
      wr(0, 8'h80);
      tick(80);
      pulse(0);
      tick(2);
      cnt(16, c, q);
      `CHK("idle core", 0, c)
      `CHK("idle periph", 4, q)
      pulse(2);
      pulse(1);
      tick(2);
      cnt(64, c, q);
      `CHK("pdown strobes", 0, c + q)
      pulse(3);
      tick(2);
      `CHK("pmr_rd", 8'h40, pmr_rd)
      cnt(8, c, q);
      `CHK("reset strobes", 2, c)
      per(p);
      `CHK("period", 4, p)
   endtask

   // ===================================================
   // Verdict and end of run
   task automatic finish_test;
      if (err_count == 0 && n_compared > 0) begin
         $display("DONE - PASS");
      end else begin
         $display("DONE - FAIL");
      end
      $finish;
   endtask

   initial begin
      t_reset();
      t_div();
      t_src();
      t_swb();
      t_pwr();
      finish_test();
   end

   // Watchdog well beyond the few thousand cycles the tests need
   initial begin
      repeat (40000) @(posedge mclk);
      err_count++;
      finish_test();
   end
endmodule

// ==== design/ecd_clock_ctrl.sv ====
// Economy clock divider with source select and switchback.
// Assumes register writes and serial events are mclk-synchronous
// one-cycle pulses; the receive pin is asynchronous.
`timescale 1ns/1ps

module ecd_clock_ctrl
   import ecd_pkg::*;
#(
   parameter int unsigned WARMUP_CYCLES = XTAL_WARMUP
) (
   input  wire logic       mclk,
   input  wire logic       rstn,
   input  wire ecd_wr_t    pmr_wr,
   input  wire ecd_wr_t    extended_interrupt_flag_register_wr,
   input  wire ecd_wr_t    amp_off_wr,
   input  wire logic       idle_req,
   input  wire logic       pdown_req,
   input  wire logic       wake,
   input  wire logic       rst_cause,
   input  wire ecd_ser_t   ser,
   input  wire logic       rx_pin,
   output logic            core_stb,
   output logic            periph_stb,
   output logic [7:0]      pmr_rd,
   output logic [7:0]      extended_interrupt_flag_register_rd,
   output logic [7:0]      status_rd,
   output logic            xtal_amp_en,
   output logic            src_xtal
);

   // =========================================================
   // Parameter check
   localparam int WARM_W = $clog2(WARMUP_CYCLES + 1);
   localparam logic [WARM_W-1:0] WARM_LAST =
      WARM_W'(WARMUP_CYCLES - 1);

   if (WARMUP_CYCLES < 1) begin : g_chk
      $error("WARMUP_CYCLES must be at least one");
   end

   // =========================================================
   // State
   ecd_div_t      div_r;            // Active divider
   ecd_div_t      pend_div_r;       // Divider waiting for cycle end
   logic          pend_vld_r;       // Divider change pending
   logic          swb_r;            // Switchback enable
   logic          src_sel_r;        // Written source select
   logic          src_act_r;        // Source actually driving
   logic          amp_off_r;        // Crystal-off request
   logic          xready_r;         // Crystal warm-up done
   logic [WARM_W-1:0] warm_r;       // Warm-up counter
   logic [9:0]    cnt_r;            // Machine-cycle counter
   logic [9:0]    lim;              // Last count of the period
   logic [1:0]    q4_r;             // Idle peripheral counter
   ecd_pmode_t    pmode_r;          // Power mode
   logic [2:0]    rx_s_r;           // Receive pin synchroniser
   logic          rx_lvl_r;         // Filtered receive level
   logic          rx_fall;          // Start-bit falling edge
   logic          mc_stb;           // Raw machine-cycle strobe
   logic          sb_trig;          // Switchback event
   logic          cd_ok;            // Divider write accepted
   logic [1:0]    cd_code;          // Written divider code
   logic          div_chg;          // Divider changes this cycle

   // =========================================================
   // Receive pin: three flops, level moves once stages 2 and 3 agree
   always_ff @(posedge mclk) begin
      if (!rstn) begin
         rx_s_r   <= 3'h7;
         rx_lvl_r <= 1'b1;
      end else begin
         rx_s_r <= {rx_s_r[1:0], rx_pin};
         if (rx_s_r[1] == rx_s_r[2]) begin
            rx_lvl_r <= rx_s_r[2];
         end
      end
   end

   // Falling edge of the start bit
   assign rx_fall = rx_lvl_r && !rx_s_r[1] && !rx_s_r[2];

   // =========================================================
   // Switchback and divider write qualification
   // Serial interrupt flags are not inputs here at all [RULE18]
   assign sb_trig = swb_r && (ser.tx_wr                    // [RULE17]
                           || (ser.rx_en && rx_fall)       // [RULE16]
                           || ser.int_ack);                // [RULE15]

   // Field taken from bits 7:6 of the written byte [RULE3]
   assign cd_code = {pmr_wr.data[PMR_CD_HI_POS],
                     pmr_wr.data[PMR_CD_LO_POS]};

   // Reserved code and serial-busy writes are dropped [RULE26] [RULE20]
   assign cd_ok = pmr_wr.wr && (cd_code != ECD_DIV_RSVD)
               && !(swb_r && (ser.busy || ser.tx_wr || rx_fall));

   // =========================================================
   // Machine-cycle strobe
   always_comb begin
      case (div_r)
         ECD_DIV64:   lim = 10'(DIV64_CLKS - 1);           // [RULE2]
         ECD_DIV1024: lim = 10'(DIV1024_CLKS - 1);         // [RULE2]
         default:     lim = 10'(DIV4_CLKS - 1);            // [RULE2]
      endcase
   end

   // One-clock strobe when the period ends, none in power-down
   assign mc_stb = (cnt_r == lim) && (pmode_r != ECD_PDOWN); // [RULE27]

   // Divider differs next cycle
   assign div_chg = (rst_cause || sb_trig) ? (div_r != ECD_DIV4)
                  : (mc_stb && pend_vld_r && pend_div_r != div_r);

   // Counter restarts on wrap or divider change, frozen in power-down;
   // a forced return to four clocks restarts it even in power-down, so
   // a count left above the new limit cannot delay the first strobe
   always_ff @(posedge mclk) begin
      if (!rstn) begin
         cnt_r <= 10'h000;
      end else if (mc_stb || div_chg) begin
         cnt_r <= 10'h000;                                 // [RULE21]
      end else if (pmode_r == ECD_PDOWN) begin
         cnt_r <= cnt_r;                                   // [RULE24]
      end else begin
         cnt_r <= cnt_r + 10'h001;
      end
   end

   // =========================================================
   // Divider select, pending change and switchback
   always_ff @(posedge mclk) begin
      if (!rstn) begin
         div_r      <= ECD_DIV_RESET;                      // [RULE1]
         pend_div_r <= ECD_DIV_RESET;
         pend_vld_r <= 1'b0;
      end else if (rst_cause || sb_trig) begin
         // Immediate return to four clocks [RULE21] [RULE15] [RULE25]
         div_r      <= ECD_DIV4;
         pend_vld_r <= 1'b0;
      end else begin
         if (mc_stb && pend_vld_r) begin
            div_r <= pend_div_r;                           // [RULE4]
         end
         // Always writable again after a switchback [RULE19]
         if (cd_ok) begin
            pend_div_r <= ecd_div_t'(cd_code);
            pend_vld_r <= 1'b1;
         end else if (mc_stb) begin
            pend_vld_r <= 1'b0;
         end
      end
   end

   // Switchback enable bit
   always_ff @(posedge mclk) begin
      if (!rstn) begin
         swb_r <= SWB_RESET;
      end else if (pmr_wr.wr) begin
         swb_r <= pmr_wr.data[PMR_SWB_POS];
      end
   end

   // =========================================================
   // Clock source select and active source
   always_ff @(posedge mclk) begin
      if (!rstn) begin
         src_sel_r <= SRC_SEL_RESET;
         src_act_r <= SRC_SEL_RESET;
      end else begin
         // Crystal request refused until warm-up is done [RULE14]
         if (extended_interrupt_flag_register_wr.wr && (xready_r
                            || !extended_interrupt_flag_register_wr.data[EXTENDED_INTERRUPT_FLAG_REGISTER_SRC_SEL_POS])) begin
            src_sel_r <= extended_interrupt_flag_register_wr.data[EXTENDED_INTERRUPT_FLAG_REGISTER_SRC_SEL_POS];   // [RULE8]
         end
         if (mc_stb) begin
            src_act_r <= src_sel_r;                        // [RULE11]
         end
      end
   end

   // Crystal-off request bit
   always_ff @(posedge mclk) begin
      if (!rstn) begin
         amp_off_r <= 1'b0;
      end else if (amp_off_wr.wr) begin
         amp_off_r <= amp_off_wr.data[0];
      end
   end

   // Amplifier only stops while the RC source is active [RULE9]
   assign xtal_amp_en = !(amp_off_r && !src_act_r);

   // =========================================================
   // Crystal warm-up: restarts whenever the amplifier is off
   always_ff @(posedge mclk) begin
      if (!rstn) begin
         warm_r   <= '0;
         xready_r <= 1'b0;
      end else if (!xtal_amp_en) begin
         warm_r   <= '0;
         xready_r <= 1'b0;
      end else if (!xready_r) begin
         if (warm_r == WARM_LAST) begin
            xready_r <= 1'b1;                              // [RULE13]
         end else begin
            warm_r <= warm_r + WARM_W'(1);
         end
      end
   end

   // =========================================================
   // Power modes
   always_ff @(posedge mclk) begin
      if (!rstn) begin
         pmode_r <= ECD_RUN;
      end else begin
         case (pmode_r)
            ECD_RUN: begin
               if (pdown_req) begin
                  pmode_r <= ECD_PDOWN;                    // [RULE24]
               end else if (idle_req) begin
                  pmode_r <= ECD_IDLE;                     // [RULE23]
               end
            end
            ECD_IDLE: begin
               if (wake || rst_cause) begin
                  pmode_r <= ECD_RUN;
               end
            end
            ECD_PDOWN: begin
               if (wake || rst_cause) begin
                  pmode_r <= ECD_RUN;
               end
            end
            default: begin
               pmode_r <= ECD_RUN;
            end
         endcase
      end
   end

   // Fixed clock/4 tick for peripherals during idle
   always_ff @(posedge mclk) begin
      if (!rstn) begin
         q4_r <= 2'h0;
      end else begin
         q4_r <= q4_r + 2'h1;
      end
   end

   // =========================================================
   // Strobes and readback
   assign core_stb   = mc_stb && (pmode_r == ECD_RUN);     // [RULE23]
   // Run: same reduced rate [RULE7]; idle: clock/4 [RULE6]
   assign periph_stb = (pmode_r == ECD_RUN) ? mc_stb
                     : (pmode_r == ECD_IDLE)
                       && (q4_r == 2'(IDLE_CLKS - 1));

   always_comb begin
      pmr_rd    = 8'h00;
      extended_interrupt_flag_register_rd   = 8'h00;
      status_rd = 8'h00;
      pmr_rd[PMR_CD_HI_POS]      = div_r[1];
      pmr_rd[PMR_CD_LO_POS]      = div_r[0];               // [RULE25]
      pmr_rd[PMR_SWB_POS]        = swb_r;
      extended_interrupt_flag_register_rd[EXTENDED_INTERRUPT_FLAG_REGISTER_SRC_SEL_POS]  = src_sel_r;
      extended_interrupt_flag_register_rd[EXTENDED_INTERRUPT_FLAG_REGISTER_SRC_STAT_POS] = src_act_r;              // [RULE10]
      status_rd[STAT_XREADY_POS] = xready_r;
   end

   assign src_xtal = src_act_r;

   // =========================================================
   // Checks
   sequence s_quiet3;
      !mc_stb [*3];
   endsequence

   sequence s_idle5;
      (pmode_r == ECD_IDLE) [*5];
   endsequence

   reset_div4_a: assert property (@(posedge mclk)  // [RULE1]
      !$past(rstn) && rstn && !pdown_req |-> s_quiet3 ##1 mc_stb)
      else $error("first machine cycle after reset not four clocks");

   cd_delay_a: assert property (@(posedge mclk) disable iff (!rstn)
      cd_ok && !mc_stb && !sb_trig && !rst_cause   // [RULE4]
      |=> div_r == $past(div_r))
      else $error("divider changed without a machine-cycle delay");

   rsvd_code_a: assert property (@(posedge mclk) disable iff (!rstn)
      pmr_wr.wr && cd_code == 2'h0 && !pend_vld_r  // [RULE26]
      |=> !pend_vld_r)
      else $error("reserved divider code was accepted");

   switchback_a: assert property (@(posedge mclk) disable iff (!rstn)
      sb_trig || rst_cause                         // [RULE15]
      |=> div_r == ECD_DIV4 && pmr_rd[7:6] == 2'h1 && !pend_vld_r)
      else $error("switchback or reset did not restore four clocks");

   busy_lock_a: assert property (@(posedge mclk) disable iff (!rstn)
      swb_r && ser.busy && pmr_wr.wr && !pend_vld_r // [RULE20]
      |=> !pend_vld_r)
      else $error("divider write taken during serial activity");

   xtal_refuse_a: assert property (@(posedge mclk) disable iff (!rstn)
      extended_interrupt_flag_register_wr.wr && extended_interrupt_flag_register_wr.data[EXTENDED_INTERRUPT_FLAG_REGISTER_SRC_SEL_POS] && !xready_r // [RULE14]
      |=> src_sel_r == $past(src_sel_r))
      else $error("crystal selected before warm-up");

   src_delay_a: assert property (@(posedge mclk) disable iff (!rstn)
      src_act_r != $past(src_act_r)                // [RULE11]
      |-> $past(mc_stb) && extended_interrupt_flag_register_rd[EXTENDED_INTERRUPT_FLAG_REGISTER_SRC_STAT_POS] == $past(src_sel_r))
      else $error("source switched outside a machine-cycle edge");

   idle_rate_a: assert property (@(posedge mclk) disable iff (!rstn)
      s_idle5 ##0 periph_stb                       // [RULE6]
      |-> !core_stb && $past(periph_stb, 4) && !$past(periph_stb))
      else $error("idle peripheral tick not every four clocks");

   pdown_stop_a: assert property (@(posedge mclk) disable iff (!rstn)
      pmode_r == ECD_PDOWN                         // [RULE24]
      |-> !core_stb && !periph_stb ##1
          ($stable(cnt_r) || $past(rst_cause) || $past(sb_trig)))
      else $error("clock activity in power-down");

   amp_off_a: assert property (@(posedge mclk) disable iff (!rstn)
      amp_off_r && !src_act_r                      // [RULE9]
      |=> !xready_r || !amp_off_r || src_act_r)
      else $error("crystal stayed ready with amplifier off");

endmodule

// ==== pkg/ecd_pkg.sv ====
// Constants, types and carriers for the economy clock divider block.
// Assumes one mclk domain; register bytes arrive as plain write ports.
//
// Notes on behaviour
// RULE1: After reset, four clocks per machine cycle.
// RULE2: Code 01=4, 10=64, 11=1024 clocks; 00 reserved.
// RULE3: Divider field sits in register bits 7:6.
// RULE4: New divider applies one machine cycle later.
// RULE5: Software changes 64/1024 only via divide-by-4.
// RULE6: Idle stops core; peripherals tick at clock/4.
// RULE7: Economy mode slows peripherals like the core.
// RULE8: Source select bit 3: crystal set, RC clear.
// RULE9: Crystal-off stops amplifier while RC runs.
// RULE10: Read-only bit 2 shows active clock source.
// RULE11: Source change applies one machine cycle later.
// RULE12: Software clears crystal-off before selecting crystal.
// RULE13: Crystal-ready flag bit 4 set after warm-up.
// RULE14: Crystal select refused while crystal not ready.
// RULE15: Switchback restores divide-by-4 on qualified events.
// RULE16: Start-bit falling edge triggers switchback.
// RULE17: Transmit buffer write triggers switchback.
// RULE18: Switchback ignores serial interrupt flags.
// RULE19: Divider stays writable after a switchback.
// RULE20: Divider writes ignored during serial activity.
// RULE21: Watchdog, power and external resets force four.
// RULE22: Software avoids RC source for serial timing.
// RULE23: Idle stops CPU clock, peripherals keep running.
// RULE24: Power-down stops every clock.
// RULE25: Switchback and reset read back code 01.
// RULE26: Reserved code 00 write changes nothing; the code still loads the switchback bit 5 from that write.
// RULE27: One-clock machine-cycle strobe each selected period.

package ecd_pkg;

   // =========================================================
   // Register field positions
   localparam int PMR_CD_LO_POS     = 6;  // Divider select low bit
   localparam int PMR_CD_HI_POS     = 7;  // Divider select high bit
   localparam int PMR_SWB_POS       = 5;  // Switchback enable
   localparam int EXTENDED_INTERRUPT_FLAG_REGISTER_SRC_SEL_POS  = 3;  // Clock source select
   localparam int EXTENDED_INTERRUPT_FLAG_REGISTER_SRC_STAT_POS = 2;  // Active source status
   localparam int STAT_XREADY_POS   = 4;  // Crystal ready flag

   // =========================================================
   // Divider codes and clock counts
   typedef enum logic [1:0] {
      ECD_DIV_RSVD = 2'h0,                 // Reserved code
      ECD_DIV4     = 2'h1,                 // Four clocks
      ECD_DIV64    = 2'h2,                 // Sixty-four clocks
      ECD_DIV1024  = 2'h3                  // 1024 clocks
   } ecd_div_t;

   localparam ecd_div_t ECD_DIV_RESET = ECD_DIV4;   // Reset divider
   localparam logic     SRC_SEL_RESET = 1'b1;       // Reset: crystal
   localparam logic     SWB_RESET     = 1'b0;       // Reset: off
   localparam int       DIV4_CLKS     = 4;
   localparam int       DIV64_CLKS    = 64;
   localparam int       DIV1024_CLKS  = 1024;
   localparam int       IDLE_CLKS     = 4;          // Idle periph rate
   localparam int       XTAL_WARMUP   = 65536;      // Warm-up cycles

   // =========================================================
   // Power modes, Gray coded along run, idle, power-down
   typedef enum logic [1:0] {
      ECD_RUN   = 2'h0,
      ECD_IDLE  = 2'h1,
      ECD_PDOWN = 2'h3
   } ecd_pmode_t;

   // Byte write carrier for one register
   typedef struct packed {
      logic       wr;                      // One-cycle write strobe
      logic [7:0] data;                    // Written byte
   } ecd_wr_t;

   // Serial and interrupt event carrier
   typedef struct packed {
      logic rx_en;                         // Reception enabled
      logic busy;                          // Transfer in progress
      logic tx_wr;                         // Transmit buffer write
      logic int_ack;                       // Qualified ext interrupt
   } ecd_ser_t;

endpackage
